/* src/ivf_pkg.sv */
// Package for the input-voltage fault response block
package ivf_pkg;
  localparam logic [7:0] ADDR_HIGH_WARN  = 8'h57;
  localparam logic [7:0] ADDR_LOW_WARN   = 8'h58;
  localparam logic [7:0] ADDR_LOW_FAULT  = 8'h59;
  localparam logic [7:0] ADDR_LOW_ACTION = 8'h5a;
  localparam logic [15:0] HIGH_WARN_RST   = 16'hffff;
  localparam logic [15:0] LOW_WARN_RST    = 16'h0000;
  localparam logic [15:0] LOW_FAULT_RST   = 16'h0000;
  localparam logic [7:0]  LOW_ACTION_RST  = 8'h00;
  localparam int RESP_HI = 7;
  localparam int RESP_LO = 6;
  localparam int RETRY_HI = 5;
  localparam int RETRY_LO = 3;
  localparam int DELAY_HI = 2;
  localparam int DELAY_LO = 0;
  localparam logic [2:0] RETRY_NONE     = 3'h0;
  localparam logic [2:0] RETRY_FOREVER  = 3'h7;
  localparam int UNIT_W  = 16;
  localparam int COUNT_W = 24;
  localparam logic [UNIT_W-1:0] UNIT_CYCLES_DEF = 16'h0028;
  localparam logic [COUNT_W-1:0] COUNT_ONE = 24'h000001;

  typedef enum logic [1:0] {RESP_IGNORE, RESP_OPERATE, RESP_DISABLE, RESP_LATCH} ivf_resp_t;

  typedef struct packed {
    logic       wrEn;
    logic       rdEn;
    logic [7:0] addr;
    logic [15:0] wrData;
  } ivf_req_t;

  typedef struct packed {
    logic        highWarn;
    logic        lowWarn;
    logic        lowFault;
  } ivf_flags_t;
endpackage

/* src/ivf_cmp.sv */
// Threshold comparators for the measured input voltage
`timescale 1ns/10ps
`default_nettype none
module ivf_cmp
  import ivf_pkg::*;
(
  input  wire logic        clk_sys,
  input  wire logic        rstn,
  input  wire logic [15:0] vinMeas,
  input  wire logic [15:0] highWarnLim,
  input  wire logic [15:0] lowWarnLim,
  input  wire logic [15:0] lowFaultLim,
  output var ivf_flags_t   flags
);
  ivf_flags_t flags_d;
  ivf_flags_t flags_q;

  always_comb begin
    flags_d.highWarn = vinMeas > highWarnLim;
    flags_d.lowWarn  = vinMeas < lowWarnLim;
    flags_d.lowFault = vinMeas < lowFaultLim;
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      flags_q <= '0;
    end else begin
      flags_q <= flags_d;
    end
  end

  assign flags = flags_q;
endmodule
`default_nettype wire

/* src/ivf_core.sv */
// Input-voltage supervision with programmable low-input fault response
// Behaviour
// - Read/write 16-bit high warning threshold
// - Read/write 16-bit low warning threshold
// - Read/write 16-bit low fault threshold
// - Response 00 ignores the fault
// - Response 01 runs delay, then retry setting
// - Response 10 disables at once, then retry setting
// - Response 11 latches off until cleared
// - Reset or off/on cycle also clears
// - Retry code 000 never restarts
// - Retry code 001 restarts once
// - Restart spacing is delay count times unit
// - Delay codes 6,7 give 64,128 units
// - Codes 010..110 give two to six restarts
// - Code 111 retries without limit
// - Delay field is power-of-two unit count
`timescale 1ns/10ps
`default_nettype none
module ivf_core
  import ivf_pkg::*;
(
  input  wire logic              clk_sys,
  input  wire logic              rstn,
  input  wire ivf_req_t          req,
  output logic [15:0]            rdData,
  output logic                   rdValid,
  input  wire logic [15:0]       vinMeas,
  input  wire logic [UNIT_W-1:0] unitCycles,
  input  wire logic              outCmdOn,
  input  wire logic              clearFaults,
  input  wire logic              clearStatus,
  output logic                   outEnable,
  output logic                   highWarnFlag,
  output logic                   lowWarnFlag,
  output logic                   lowFaultStatus,
  output logic                   latchedOff
);
  typedef enum logic [1:0] {ST_RUN, ST_WAIT, ST_OFF, ST_LATCH} ivf_state_t;

  logic [15:0] hiWarn_q, hiWarn_d, loWarn_q, loWarn_d, loFault_q, loFault_d;
  logic [7:0]  action_q, action_d;
  logic [15:0] rdData_q, rdData_d;
  logic        rdValid_q, rdValid_d;
  ivf_flags_t  flags;
  ivf_state_t  st_q, st_d;
  logic [COUNT_W-1:0] cnt_q, cnt_d;
  logic [2:0]  tries_q, tries_d;
  logic        en_q, en_d, stat_q, stat_d, cmdOn_q;
  logic        hw_q, lw_q;
  logic        latch_q, latch_d;
  ivf_resp_t   resp;
  logic [2:0]  retries;
  logic [COUNT_W-1:0] delayCycles;
  logic        offCycle, clr;

  ivf_cmp u_cmp (
    .clk_sys     (clk_sys),
    .rstn        (rstn),
    .vinMeas     (vinMeas),
    .highWarnLim (hiWarn_q),
    .lowWarnLim  (loWarn_q),
    .lowFaultLim (loFault_q),
    .flags       (flags)
  );

  // Register file
  always_comb begin
    hiWarn_d  = hiWarn_q;
    loWarn_d  = loWarn_q;
    loFault_d = loFault_q;
    action_d  = action_q;
    rdData_d  = rdData_q;
    rdValid_d = req.rdEn;
    if (req.wrEn) begin
      unique case (req.addr)
        ADDR_HIGH_WARN:  hiWarn_d  = req.wrData;
        ADDR_LOW_WARN:   loWarn_d  = req.wrData;
        ADDR_LOW_FAULT:  loFault_d = req.wrData;
        ADDR_LOW_ACTION: action_d  = req.wrData[7:0];
        default: ;
      endcase
    end
    if (req.rdEn) begin
      unique case (req.addr)
        ADDR_HIGH_WARN:  rdData_d = hiWarn_q;
        ADDR_LOW_WARN:   rdData_d = loWarn_q;
        ADDR_LOW_FAULT:  rdData_d = loFault_q;
        ADDR_LOW_ACTION: rdData_d = {8'h00, action_q};
        default:         rdData_d = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      hiWarn_q  <= HIGH_WARN_RST;
      loWarn_q  <= LOW_WARN_RST;
      loFault_q <= LOW_FAULT_RST;
      action_q  <= LOW_ACTION_RST;
      rdData_q  <= 16'h0000;
      rdValid_q <= 1'b0;
    end else begin
      hiWarn_q  <= hiWarn_d;
      loWarn_q  <= loWarn_d;
      loFault_q <= loFault_d;
      action_q  <= action_d;
      rdData_q  <= rdData_d;
      rdValid_q <= rdValid_d;
    end
  end

  assign resp    = ivf_resp_t'(action_q[RESP_HI:RESP_LO]);
  assign retries = action_q[RETRY_HI:RETRY_LO];
  // Unit count is 2**code, so code 6 is 64 and 7 is 128 units
  assign delayCycles = COUNT_W'(unitCycles) << action_q[DELAY_HI:DELAY_LO];
  assign offCycle = cmdOn_q && !outCmdOn;
  assign clr = clearFaults || clearStatus || offCycle;

  // Fault response sequencer
  always_comb begin
    st_d    = st_q;
    cnt_d   = cnt_q;
    tries_d = tries_q;
    en_d    = en_q;
    stat_d  = stat_q || flags.lowFault;
    if (clearFaults || clearStatus) stat_d = flags.lowFault;
    unique case (st_q)
      ST_RUN: begin
        en_d    = outCmdOn;
        tries_d = 3'h0;
        if (flags.lowFault && outCmdOn) begin
          unique case (resp)
            RESP_IGNORE: ;
            RESP_OPERATE: begin
              st_d  = ST_WAIT;
              cnt_d = delayCycles;
            end
            RESP_DISABLE: begin
              en_d = 1'b0;
              if (retries == RETRY_NONE) begin
                st_d = ST_LATCH;
              end else begin
                st_d  = ST_OFF;
                cnt_d = delayCycles;
              end
            end
            RESP_LATCH: begin
              en_d = 1'b0;
              st_d = ST_LATCH;
            end
          endcase
        end
      end
      ST_WAIT: begin
        cnt_d = cnt_q - COUNT_ONE;
        if (!flags.lowFault || !outCmdOn) begin
          st_d = ST_RUN;
        end else if (cnt_q <= COUNT_ONE) begin
          en_d = 1'b0;
          if (retries == RETRY_NONE) begin
            st_d = ST_LATCH;
          end else begin
            st_d  = ST_OFF;
            cnt_d = delayCycles;
          end
        end
      end
      ST_OFF: begin
        en_d  = 1'b0;
        cnt_d = cnt_q - COUNT_ONE;
        if (!outCmdOn) begin
          st_d = ST_RUN;
        end else if (cnt_q <= COUNT_ONE) begin
          if (flags.lowFault) begin
            if (retries != RETRY_FOREVER && tries_q + 3'h1 >= retries) begin
              st_d = ST_LATCH;
            end else begin
              tries_d = tries_q + 3'h1;
              cnt_d   = delayCycles;
            end
          end else begin
            en_d = 1'b1;
            st_d = ST_RUN;
          end
        end
      end
      ST_LATCH: begin
        en_d = 1'b0;
        if (clr) st_d = ST_RUN;
      end
    endcase
    // Latched-off output is registered alongside the state
    latch_d = (st_d == ST_LATCH);
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      st_q    <= ST_RUN;
      cnt_q   <= '0;
      tries_q <= 3'h0;
      en_q    <= 1'b0;
      stat_q  <= 1'b0;
      cmdOn_q <= 1'b0;
      hw_q    <= 1'b0;
      lw_q    <= 1'b0;
      latch_q <= 1'b0;
    end else begin
      st_q    <= st_d;
      cnt_q   <= cnt_d;
      tries_q <= tries_d;
      en_q    <= en_d;
      stat_q  <= stat_d;
      cmdOn_q <= outCmdOn;
      hw_q    <= flags.highWarn;
      lw_q    <= flags.lowWarn;
      latch_q <= latch_d;
    end
  end

  assign rdData         = rdData_q;
  assign rdValid        = rdValid_q;
  assign outEnable      = en_q;
  assign highWarnFlag   = hw_q;
  assign lowWarnFlag    = lw_q;
  assign lowFaultStatus = stat_q;
  assign latchedOff     = latch_q;

  a_ignore_keeps_on: assert property (@(posedge clk_sys) disable iff (!rstn)
    (st_q == ST_RUN && resp == RESP_IGNORE && outCmdOn) |=> en_q)
    else $error("Output dropped with ignore response");
  a_latch_holds_off: assert property (@(posedge clk_sys) disable iff (!rstn)
    (st_q == ST_LATCH && !clr) |=> (st_q == ST_LATCH) && !en_q)
    else $error("Latched-off state left without clear");
  a_disable_immediate: assert property (@(posedge clk_sys) disable iff (!rstn)
    (st_q == ST_RUN && flags.lowFault && outCmdOn && resp == RESP_DISABLE) |=> !en_q)
    else $error("Disable response did not drop output");
  a_no_retry_latch: assert property (@(posedge clk_sys) disable iff (!rstn)
    (st_q == ST_RUN && flags.lowFault && outCmdOn && resp == RESP_DISABLE
     && retries == RETRY_NONE) |=> (st_q == ST_LATCH))
    else $error("Zero retry code did not latch");
  a_clear_releases: assert property (@(posedge clk_sys) disable iff (!rstn)
    (st_q == ST_LATCH && clr) |=> (st_q == ST_RUN))
    else $error("Clear did not release latch");
  a_wait_keeps_on: assert property (@(posedge clk_sys) disable iff (!rstn)
    (st_q == ST_WAIT && cnt_q > COUNT_ONE) |=> en_q == $past(en_q))
    else $error("Output changed during operate delay");
  a_delay_loaded: assert property (@(posedge clk_sys) disable iff (!rstn)
    (st_q == ST_RUN && st_d == ST_WAIT) |=> cnt_q == $past(delayCycles))
    else $error("Operate delay not loaded");
  a_off_no_enable: assert property (@(posedge clk_sys) disable iff (!rstn)
    (st_q == ST_OFF) |-> !en_q || $past(st_q) != ST_OFF)
    else $error("Output on while waiting to retry");
  a_tries_bound: assert property (@(posedge clk_sys) disable iff (!rstn)
    (retries != RETRY_FOREVER && retries != RETRY_NONE) |-> tries_q < retries)
    else $error("Retry count exceeded");
  c_latch: cover property (@(posedge clk_sys) disable iff (!rstn) st_q == ST_LATCH);
  c_wait: cover property (@(posedge clk_sys) disable iff (!rstn) st_q == ST_WAIT);
  c_restart: cover property (@(posedge clk_sys) disable iff (!rstn)
    st_q == ST_OFF ##1 st_q == ST_RUN);
  c_operate_latch: cover property (@(posedge clk_sys) disable iff (!rstn)
    st_q == ST_WAIT ##1 st_q == ST_LATCH);
  c_forever: cover property (@(posedge clk_sys) disable iff (!rstn)
    st_q == ST_OFF && retries == RETRY_FOREVER);

  // Register bus checks
  a_high_write_lands: assert property (@(posedge clk_sys) disable iff (!rstn)
    (req.wrEn && req.addr == ADDR_HIGH_WARN) |=> hiWarn_q == $past(req.wrData))
    else $error("High warning threshold write lost");
  a_lowwarn_write_lands: assert property (@(posedge clk_sys) disable iff (!rstn)
    (req.wrEn && req.addr == ADDR_LOW_WARN) |=> loWarn_q == $past(req.wrData))
    else $error("Low warning threshold write lost");
  a_lowfault_write_lands: assert property (@(posedge clk_sys) disable iff (!rstn)
    (req.wrEn && req.addr == ADDR_LOW_FAULT) |=> loFault_q == $past(req.wrData))
    else $error("Low fault threshold write lost");
  a_high_read_returns: assert property (@(posedge clk_sys) disable iff (!rstn)
    (req.rdEn && req.addr == ADDR_HIGH_WARN) |=> rdValid_q && rdData_q == $past(hiWarn_q))
    else $error("High warning threshold read wrong");
  a_rdvalid_pulse: assert property (@(posedge clk_sys) disable iff (!rstn)
    rdValid_q |-> $past(req.rdEn))
    else $error("Read valid without a read request");

  // Sequencer checks
  a_ignore_no_latch: assert property (@(posedge clk_sys) disable iff (!rstn)
    (st_q == ST_RUN && resp == RESP_IGNORE) |=> st_q == ST_RUN)
    else $error("Ignore response left run state");
  a_forever_no_latch: assert property (@(posedge clk_sys) disable iff (!rstn)
    (st_q == ST_OFF && retries == RETRY_FOREVER) |=> st_q != ST_LATCH)
    else $error("Endless retry latched off");
  a_retry_spacing: assert property (@(posedge clk_sys) disable iff (!rstn)
    (st_q == ST_OFF && $past(st_q) != ST_OFF) |-> cnt_q == $past(delayCycles))
    else $error("Retry interval not loaded");
  a_latch_output_off: assert property (@(posedge clk_sys) disable iff (!rstn)
    latch_q |-> !en_q)
    else $error("Output on while latched off");
  a_delay_longest: assert property (@(posedge clk_sys) disable iff (!rstn)
    (action_q[DELAY_HI:DELAY_LO] == 3'h7) |-> delayCycles == {unitCycles, 7'h00})
    else $error("Delay code seven is not 128 units");
  a_status_sticky: assert property (@(posedge clk_sys) disable iff (!rstn)
    flags.lowFault |=> stat_q)
    else $error("Low fault status not set");
endmodule
`default_nettype wire

/* test/ivf_host.sv */
// Host controller model that issues register requests to the block
`timescale 1ns/10ps
`default_nettype none
module ivf_host
  import ivf_pkg::*;
(
  input  wire logic   clk_sys,
  input  wire logic   rstn,
  output var ivf_req_t req
);
  initial req = '0;
  // Waits out reset, idles for gap cycles, then holds one request for exactly one edge
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [15:0] d,
                      input int gap);
    @(posedge clk_sys);
    while (rstn !== 1'b1) @(posedge clk_sys);
    repeat (gap) @(posedge clk_sys);
    #2;
    req = '{wrEn: wr, rdEn: !wr, addr: a, wrData: d};
    @(posedge clk_sys);
    #2;
    req = '0;
  endtask
endmodule
`default_nettype wire

/* test/testbench.sv */
// Self-checking bench for the input-voltage fault response block
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, e, s) begin checked++; if ((s) !== (e)) begin n_errors++; \
  $display("BAD %s expected %0h seen %0h", nm, e, s); end end
module testbench
  import ivf_pkg::*;
;
  logic              clk_sys = 1'b0;
  logic              rstn = 1'b0;
  ivf_req_t          req;
  logic [15:0]       rdData;
  logic              rdValid;
  logic [15:0]       vinMeas = 16'h8000;
  logic [UNIT_W-1:0] unitCycles = 16'h0004;
  logic              outCmdOn = 1'b1;
  logic              clearFaults = 1'b0;
  logic              clearStatus = 1'b0;
  logic              outEnable, highWarnFlag, lowWarnFlag, lowFaultStatus, latchedOff;
  int                n_errors = 0;
  int                checked = 0;
  logic [15:0]       expQ[$];
  int                codes[3] = '{3, 6, 7};

  always #12.5 clk_sys = ~clk_sys;

  ivf_host host (.clk_sys, .rstn, .req);
  ivf_core uut (.clk_sys, .rstn, .req, .rdData, .rdValid, .vinMeas, .unitCycles, .outCmdOn,
                .clearFaults, .clearStatus, .outEnable, .highWarnFlag, .lowWarnFlag,
                .lowFaultStatus, .latchedOff);

  task automatic final_report();
    if (n_errors == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  task automatic tick(input int k);
    repeat (k) @(posedge clk_sys);
    #2;
  endtask

  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    host.xfer(1'b1, a, d, int'($urandom_range(1, 0)));
  endtask

  task automatic rd(input logic [7:0] a, input logic [15:0] e);
    expQ.push_back(e);
    host.xfer(1'b0, a, 16'h0000, 0);
  endtask

  // With normal input, program the action, clear any latch, then drop the input below the limit
  task automatic arm(input logic [7:0] act);
    vinMeas = 16'h8000;
    wr(ADDR_LOW_ACTION, {8'h00, act});
    tick(1);
    clearFaults = 1'b1;
    tick(1);
    clearFaults = 1'b0;
    tick(4);
    `CHK("outEnableArmed", 1'b1, outEnable);
    vinMeas = 16'h1000;
  endtask

  task automatic cyclesTo(input int lim, output int n);
    n = 0;
    while (latchedOff !== 1'b1 && n < lim) begin
      tick(1);
      n++;
    end
  endtask

  always @(posedge clk_sys) begin
    logic [15:0] ev;
    if (rdValid === 1'b1) begin
      ev = (expQ.size() > 0) ? expQ.pop_front() : 16'hxxxx;
      `CHK("rdData", ev, rdData);
    end
  end

  initial begin
    repeat (20000) @(posedge clk_sys);
    n_errors++;
    final_report();
  end

  initial begin
    int n;
    int d;
    logic [15:0] v;
    void'($urandom(63319));
    tick(3);
    rstn = 1'b1;
    rd(ADDR_HIGH_WARN, HIGH_WARN_RST);
    rd(ADDR_LOW_WARN, LOW_WARN_RST);
    rd(ADDR_LOW_FAULT, LOW_FAULT_RST);
    rd(ADDR_LOW_ACTION, {8'h00, LOW_ACTION_RST});
    wr(8'h5b, 16'h5a5a);
    rd(8'h5b, 16'h0000);
    for (int i = 0; i < 4; i++) begin
      v = 16'($urandom());
      // Random action byte keeps the ignore response so no sequence starts here
      if (i == 3) v[7:6] = 2'b00;
      wr(ADDR_HIGH_WARN + 8'(i), v);
      rd(ADDR_HIGH_WARN + 8'(i), (i == 3) ? {8'h00, v[7:0]} : v);
    end
    wr(ADDR_HIGH_WARN, 16'hc000);
    wr(ADDR_LOW_WARN, 16'h6000);
    wr(ADDR_LOW_FAULT, 16'h4000);
    vinMeas = 16'hd000;
    tick(4);
    `CHK("highWarnFlag", 1'b1, highWarnFlag);
    vinMeas = 16'h5000;
    tick(4);
    `CHK("highWarnFlag", 1'b0, highWarnFlag);
    `CHK("lowWarnFlag", 1'b1, lowWarnFlag);
    arm(8'h00);
    tick(40);
    `CHK("outEnableIgnore", 1'b1, outEnable);
    `CHK("lowFaultStatus", 1'b1, lowFaultStatus);
    arm(8'hc0);
    tick(5);
    vinMeas = 16'h8000;
    tick(20);
    `CHK("outEnableLatched", 1'b0, outEnable);
    clearStatus = 1'b1;
    tick(1);
    clearStatus = 1'b0;
    tick(5);
    `CHK("outEnableCleared", 1'b1, outEnable);
    arm(8'hc0);
    tick(5);
    vinMeas = 16'h8000;
    outCmdOn = 1'b0;
    tick(3);
    outCmdOn = 1'b1;
    tick(5);
    `CHK("outEnableOffOn", 1'b1, outEnable);
    arm(8'h80);
    tick(4);
    `CHK("outEnableDisable", 1'b0, outEnable);
    `CHK("latchNoRetry", 1'b1, latchedOff);
    for (int r = 1; r < 7; r++) begin
      arm({2'b10, 3'(r), 3'h1});
      d = 8;
      cyclesTo(600, n);
      `CHK("retryCycles", 1'b1, (n >= r * d && n <= r * d + 6));
    end
    arm(8'hb8);
    tick(300);
    `CHK("latchForever", 1'b0, latchedOff);
    unitCycles = 16'h0002;
    foreach (codes[k]) begin
      d = 2 << codes[k];
      arm({5'b01000, 3'(codes[k])});
      tick(6);
      `CHK("outEnableOperate", 1'b1, outEnable);
      cyclesTo(600, n);
      `CHK("delayCycles", 1'b1, (n + 6 >= d && n <= d));
    end
    final_report();
  end
endmodule
`default_nettype wire
